// ==== rtl/pmic_irq_pkg.sv ====
/*
  Constants for the latched interrupt flag block: register offsets, bit
  positions, reset values and the short-circuit qualifying time.
  Assumes a 40 MHz system clock and an 8-bit register port behind the serial front end.
*/
package pmic_irq_pkg;

  // Register offsets on the byte register port
  localparam logic [7:0] ADDR_RESET_CTRL = 8'h18;
  localparam logic [7:0] ADDR_TOP_A      = 8'h19;
  localparam logic [7:0] ADDR_TOP_B      = 8'h1A;
  localparam logic [7:0] ADDR_CONV       = 8'h1B;
  localparam logic [7:0] ADDR_LINREG     = 8'h1C;

  // Bit positions in top_event_flags_a
  localparam int TOPA_PG_DROP   = 7;
  localparam int TOPA_LINREG    = 6;
  localparam int TOPA_CONV      = 5;
  localparam int TOPA_SYNC      = 4;
  localparam int TOPA_TSD       = 3;
  localparam int TOPA_WARN      = 2;
  localparam int TOPA_OVP       = 1;
  localparam int TOPA_MEAS      = 0;

  // Bit positions in top_event_flags_b and the software reset register
  localparam int TOPB_RESET     = 0;
  localparam int SWRST_BIT      = 0;

  // Per-unit event field: unit 0 at bits 2:0, unit 1 at bits 6:4
  localparam int FLD_PG         = 2;
  localparam int FLD_SC         = 1;
  localparam int FLD_ILIM       = 0;
  localparam int UNIT1_BASE     = 4;
  localparam int UNIT0_BASE     = 0;

  // Values after reset
  localparam logic [7:0] RST_TOP_A  = 8'h00;
  localparam logic [7:0] RST_TOP_B  = 8'h00;
  localparam logic [7:0] RST_CONV   = 8'h00;
  localparam logic [7:0] RST_LINREG = 8'h00;
  localparam logic [7:0] RST_RDATA  = 8'h00;

  // Writable flag masks; reserved bits always read zero
  localparam logic [7:0] MASK_TOP_A_W1C = 8'h9F;
  localparam logic [7:0] MASK_UNIT_PAIR = 8'h77;

  // Short-circuit qualifying time
  localparam int CLK_PERIOD_PS   = 25000;
  localparam int SC_QUAL_TIME_MS = 1;
  localparam int SC_QUAL_CYCLES  = (SC_QUAL_TIME_MS * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// ==== rtl/short_qualify_timer.sv ====
/*
  Qualifying timer for one regulator output: pulses once when the output
  has stayed below its short-circuit threshold for the full limit.
  Assumes below_threshold is already synchronised to clk.
*/
`timescale 1ns/1ps
module short_qualify_timer #(
  parameter int LIMIT = 40000,
  parameter int WIDTH = $clog2(LIMIT + 1)
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic below_threshold,
  output logic      expired
);

  logic [WIDTH-1:0] count_q;
  localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT - 1);

  // Count while low, saturate at the limit, restart on recovery
  always_ff @(posedge clk) begin
    if (sys_rst || !below_threshold) begin
      count_q <= '0;
    end else if (count_q != WIDTH'(LIMIT)) begin
      count_q <= count_q + WIDTH'(1);
    end
  end

  // One pulse on the cycle the limit is reached
  assign expired = below_threshold && (count_q == LAST);

endmodule // short_qualify_timer

// ==== rtl/pmic_interrupt_flags.sv ====
/*
  Latched interrupt flags of the power-management device: top-level events,
  per-converter and per-linear-regulator events, summaries, regulator gating
  and the active-low interrupt request.
  Assumes the serial front end presents byte reads and writes on a
  single-cycle register port, and analog detector levels arrive asynchronously.
*/
//
// Notes on behaviour
// [R1] Latch power-good drop flag, bit 7, when power-good falls; hold until cleared.
// [R2] Bit 6 reads set while any linear-regulator flag pends; clears with them.
// [R3] Bit 5 reads set while any converter flag pends; clears with them.
// [R4] Latch sync-clock flag, bit 4, when the external clock appears or vanishes.
// [R5] Thermal shutdown latches bit 3, disables regulators, forces both outputs low.
// [R6] While thermal-shutdown flag stands, regulator enables are refused.
// [R7] Thermal warning latches bit 2; live level reported separately. This block has no output or register bit carrying the live level.
// [R8] Input overvoltage latches bit 1, disables regulators, forces both outputs low.
// [R9] Latch bit 0 when a load-current measurement result is ready.
// [R10] Latch reset flag at 0x1A bit 0 on supply undervoltage or software reset.
// [R11] Reset event disables regulators, restores defaults, restarts, keeps reset flag.
// [R12] Converter register 0x1B latches power-good events, bit 6 and bit 2.
// [R13] Short flag after output below threshold over 1 ms: bits 5 and 1.
// [R14] Current-limit flag when a converter limit was active: bits 4 and 0.
// [R15] Writing 1 clears that flag only; other flags unchanged.
// [R16] All flags and reserved bits read 0 after reset.
// [R17] Linear-regulator register 0x1C holds write-1-clear flags, bits 6:4 and 2:0.
// [R18] Software reset bit restores defaults, reloads settings, resets serial; self-clears.
// [R19] Interrupt request active while any flag or summary is set.
`timescale 1ns/1ps
module pmic_interrupt_flags
  import pmic_irq_pkg::*;
#(
  parameter int SC_CYCLES = pmic_irq_pkg::SC_QUAL_CYCLES,
  parameter int UNITS     = 4
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [7:0]       reg_addr,
  input  wire logic             reg_wr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_rd,
  output logic [7:0]            reg_rdata,
  output logic                  reg_rvalid,
  input  wire logic             power_good_output,
  input  wire logic             sync_clock_present,
  input  wire logic             thermal_shutdown_live,
  input  wire logic             thermal_warning_live,
  input  wire logic             input_overvoltage_live,
  input  wire logic             analog_supply_low,
  input  wire logic             load_measure_ready,
  input  wire logic [UNITS-1:0] unit_power_good,
  input  wire logic [UNITS-1:0] unit_below_short,
  input  wire logic [UNITS-1:0] unit_current_limit,
  input  wire logic [UNITS-1:0] regulator_enable_request,
  input  wire logic             general_output_a_request,
  input  wire logic             general_output_b_request,
  output logic [UNITS-1:0]      regulator_enable,
  output logic                  general_output_a,
  output logic                  general_output_b,
  output logic                  restart_request,
  output logic                  software_reset_request,
  output logic                  interrupt_request_n
);

  import pmic_irq_pkg::*;

  localparam int NSYNC = 6 + 3 * UNITS;

  logic [NSYNC-1:0] sync_meta_q;
  logic [NSYNC-1:0] sync_q;
  logic [NSYNC-1:0] prev_q;
  logic [NSYNC-1:0] async_in;
  logic             pg_s, clk_s, tsd_s, warn_s, ovp_s, uv_s;
  logic             pg_p, clk_p, tsd_p, warn_p, ovp_p, uv_p;
  logic [UNITS-1:0] upg_s, ubelow_s, uilim_s, upg_p;
  logic [UNITS-1:0] sc_expired;
  logic [7:0]       top_a_q, top_b_q, conv_q, linreg_q;
  logic [7:0]       top_a_d, top_b_d, conv_d, linreg_d;
  logic [7:0]       top_a_view;
  logic [7:0]       top_a_set, conv_set, linreg_set;
  logic [7:0]       clr_top_a, clr_top_b, clr_conv, clr_linreg;
  logic [2:0]       unit_set [UNITS];
  logic             swrst_write, reset_event, trip_event;
  logic             thermal_shutdown_flag;
  logic [UNITS-1:0] en_q, held_q;
  logic             gpo_a_q, gpo_b_q, force_low;
  logic             irq_n_q, any_pending;
  logic [7:0]       rdata_q;
  logic             rvalid_q;
  logic [7:0]       conv_keep_q;

  // Asynchronous detector levels, gathered for the synchroniser
  assign async_in = {unit_current_limit, unit_below_short, unit_power_good,
                     analog_supply_low, input_overvoltage_live, thermal_warning_live,
                     thermal_shutdown_live, sync_clock_present, power_good_output};

  // Two-stage synchroniser, then one stage of history for edges
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_meta_q <= '0;
      sync_q      <= '0;
      prev_q      <= '0;
    end else begin
      sync_meta_q <= async_in;
      sync_q      <= sync_meta_q;
      prev_q      <= sync_q;
    end
  end

  // Unpack synchronised levels and their previous values
  assign {uilim_s, ubelow_s, upg_s, uv_s, ovp_s, warn_s, tsd_s, clk_s, pg_s} = sync_q;
  assign {upg_p, uv_p, ovp_p, warn_p, tsd_p, clk_p, pg_p} = prev_q[UNITS+5:0];

  // Per-unit short qualifying timers and event fields
  genvar gi;
  generate
    for (gi = 0; gi < UNITS; gi++) begin : g_unit
      short_qualify_timer #(
        .LIMIT (SC_CYCLES)
      ) u_sc_timer (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .below_threshold (ubelow_s[gi]),
        .expired         (sc_expired[gi])
      );
      assign unit_set[gi][FLD_PG]   = upg_p[gi] && !upg_s[gi];       // [R12] [R17]
      assign unit_set[gi][FLD_SC]   = sc_expired[gi];                // [R13] [R17]
      assign unit_set[gi][FLD_ILIM] = uilim_s[gi];                   // [R14] [R17]
    end
  endgenerate

  // Event sets for each register; units 0,1 are converters, 2,3 linear regulators
  assign conv_set   = {1'b0, unit_set[1], 1'b0, unit_set[0]};
  assign linreg_set = {1'b0, unit_set[3], 1'b0, unit_set[2]};
  assign top_a_set  = {pg_p && !pg_s,                                // [R1]
                       2'b00,
                       clk_s != clk_p,                               // [R4]
                       tsd_s && !tsd_p,                              // [R5]
                       warn_s && !warn_p,                            // [R7]
                       ovp_s && !ovp_p,                              // [R8]
                       load_measure_ready};                          // [R9]

  // Write-one-to-clear decode; reserved bits never store
  assign clr_top_a  = (reg_wr && reg_addr == ADDR_TOP_A)  ? (reg_wdata & MASK_TOP_A_W1C) : 8'h00;  // [R15]
  assign clr_top_b  = (reg_wr && reg_addr == ADDR_TOP_B)  ? (reg_wdata & 8'h01) : 8'h00;           // [R15]
  assign clr_conv   = (reg_wr && reg_addr == ADDR_CONV)   ? (reg_wdata & MASK_UNIT_PAIR) : 8'h00;  // [R15]
  assign clr_linreg = (reg_wr && reg_addr == ADDR_LINREG) ? (reg_wdata & MASK_UNIT_PAIR) : 8'h00;  // [R15]

  // Software reset strobe and the combined reset event
  assign swrst_write = reg_wr && (reg_addr == ADDR_RESET_CTRL) && reg_wdata[SWRST_BIT];  // [R18]
  assign reset_event = swrst_write || (uv_s && !uv_p);               // [R10]
  assign trip_event  = top_a_set[TOPA_TSD] || top_a_set[TOPA_OVP];   // [R5] [R8]

  // Next flag values: a reset event restores defaults, a new event beats a clear
  always_comb begin
    top_a_d  = (reset_event ? RST_TOP_A  : (top_a_q  & ~clr_top_a))  | (top_a_set & MASK_TOP_A_W1C);  // [R11] [R15]
    conv_d   = (reset_event ? RST_CONV   : (conv_q   & ~clr_conv))   | conv_set;                       // [R11] [R15]
    linreg_d = (reset_event ? RST_LINREG : (linreg_q & ~clr_linreg)) | linreg_set;                     // [R11] [R15]
    top_b_d  = top_b_q & ~clr_top_b;
    if (reset_event) begin
      top_b_d = 8'h01;                                               // [R10] [R11]
    end
  end

  // Flag storage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      top_a_q  <= RST_TOP_A;                                         // [R16]
      top_b_q  <= RST_TOP_B;                                         // [R16]
      conv_q   <= RST_CONV;                                          // [R16]
      linreg_q <= RST_LINREG;                                        // [R16]
    end else begin
      top_a_q  <= top_a_d;
      top_b_q  <= top_b_d;
      conv_q   <= conv_d;
      linreg_q <= linreg_d;
    end
  end

  // Read view of the top register with live summaries
  always_comb begin
    top_a_view               = top_a_q;
    top_a_view[TOPA_LINREG]  = |linreg_q;                            // [R2]
    top_a_view[TOPA_CONV]    = |conv_q;                              // [R3]
  end

  assign thermal_shutdown_flag = top_a_q[TOPA_TSD];

  // Regulator gating: trips and reset disable, shutdown flag refuses enables
  generate
    for (gi = 0; gi < UNITS; gi++) begin : g_en
      logic unit_en_q;
      logic unit_held_q;
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          unit_en_q   <= 1'b0;
          unit_held_q <= 1'b0;
        end else if (trip_event || reset_event) begin
          unit_en_q   <= 1'b0;                                       // [R5] [R8] [R11]
          unit_held_q <= 1'b1;
        end else if (!regulator_enable_request[gi]) begin
          unit_en_q   <= 1'b0;
          unit_held_q <= 1'b0;
        end else if (!unit_en_q && !unit_held_q && !thermal_shutdown_flag) begin
          unit_en_q   <= 1'b1;                                       // [R6]
        end
      end
      // Each slice owns one bit of the enable and hold vectors
      assign en_q[gi]   = unit_en_q;
      assign held_q[gi] = unit_held_q;
    end
  endgenerate

  // Outputs held low while a shutdown or overvoltage flag stands
  assign force_low = top_a_q[TOPA_TSD] || top_a_q[TOPA_OVP];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gpo_a_q <= 1'b0;
      gpo_b_q <= 1'b0;
    end else begin
      gpo_a_q <= general_output_a_request && !force_low && !trip_event;  // [R5] [R8]
      gpo_b_q <= general_output_b_request && !force_low && !trip_event;  // [R5] [R8]
    end
  end

  // Restart and software reset strobes, one cycle each
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      restart_request        <= 1'b0;
      software_reset_request <= 1'b0;
    end else begin
      restart_request        <= reset_event;                         // [R11]
      software_reset_request <= swrst_write;                         // [R18]
    end
  end

  // Interrupt request follows pending flags
  assign any_pending = (|top_a_q) || (|top_b_q) || (|conv_q) || (|linreg_q);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= !any_pending;                                       // [R19]
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q  <= RST_RDATA;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_TOP_A:      rdata_q <= top_a_view;
          ADDR_TOP_B:      rdata_q <= top_b_q;
          ADDR_CONV:       rdata_q <= conv_q;
          ADDR_LINREG:     rdata_q <= linreg_q;
          ADDR_RESET_CTRL: rdata_q <= 8'h00;                          // [R18]
          default:         rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign reg_rdata           = rdata_q;
  assign reg_rvalid          = rvalid_q;
  assign regulator_enable    = en_q;
  assign general_output_a    = gpo_a_q;
  assign general_output_b    = gpo_b_q;
  assign interrupt_request_n = irq_n_q;

  // Helper: converter flags that a write must leave standing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_keep_q <= 8'h00;
    end else begin
      conv_keep_q <= reset_event ? 8'h00 : (conv_q & ~clr_conv);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_trip;
    trip_event;
  endsequence

  sequence s_outputs_off;
    (regulator_enable == '0) ##1 (!general_output_a && !general_output_b);
  endsequence

  a_pg_drop_latch: assert property ($fell(pg_s) |=> top_a_q[TOPA_PG_DROP])  // [R1]
    else $error("power-good drop not latched");

  a_linreg_summary: assert property ((linreg_q == 8'h00) |-> !top_a_view[TOPA_LINREG])  // [R2]
    else $error("linear regulator summary set with no flag");

  a_conv_summary: assert property ((conv_q != 8'h00) |-> top_a_view[TOPA_CONV])  // [R3]
    else $error("converter summary clear with flag pending");

  a_sync_edge_flag: assert property ((clk_s != clk_p) |=> top_a_q[TOPA_SYNC])  // [R4]
    else $error("sync clock change not latched");

  a_trip_shuts_off: assert property (s_trip |=> s_outputs_off)  // [R5]
    else $error("trip did not disable outputs");

  a_tsd_refuse_en: assert property ($rose(regulator_enable[0]) |-> !$past(thermal_shutdown_flag))  // [R6]
    else $error("regulator enabled during thermal shutdown");

  a_reset_evt_flag: assert property (reset_event |=>  // [R11]
      top_b_q[TOPB_RESET] && regulator_enable == '0 && restart_request)
    else $error("reset event handling wrong");

  a_w1c_keeps_rest: assert property ((reg_wr && reg_addr == ADDR_CONV) |=>  // [R15]
      ((conv_q & conv_keep_q) == conv_keep_q))
    else $error("write cleared an unwritten flag");

  a_reserved_zero: assert property (!conv_q[7] && !conv_q[3] && !linreg_q[7] && !linreg_q[3] &&  // [R16]
      top_b_q[7:1] == 7'h00)
    else $error("reserved bit set");

  a_meas_latch: assert property (load_measure_ready |=> top_a_q[TOPA_MEAS])  // [R9]
    else $error("measurement ready not latched");

  a_warn_latch: assert property ($rose(warn_s) |=> top_a_q[TOPA_WARN])  // [R7]
    else $error("thermal warning not latched");

  a_reset_src_flag: assert property ($rose(uv_s) |=> top_b_q[TOPB_RESET])  // [R10]
    else $error("undervoltage reset not latched");

  a_unit_pg_flag: assert property ($fell(upg_s[0]) |=> conv_q[UNIT0_BASE + FLD_PG])  // [R12]
    else $error("converter power-good event not latched");

  a_short_flag: assert property (sc_expired[1] |=> conv_q[UNIT1_BASE + FLD_SC])  // [R13]
    else $error("converter short not latched");

  a_ilim_flag: assert property (uilim_s[3] |=> linreg_q[UNIT1_BASE + FLD_ILIM])  // [R14] [R17]
    else $error("regulator current limit not latched");

  a_gpo_forced_low: assert property (force_low |=> !general_output_a && !general_output_b)  // [R5] [R8]
    else $error("general outputs not forced low");

  a_irq_follows: assert property (any_pending |=> !interrupt_request_n)  // [R19]
    else $error("interrupt request not asserted");

  a_irq_release: assert property ((!any_pending) [*2] |-> interrupt_request_n)  // [R19]
    else $error("interrupt request not released");

endmodule // pmic_interrupt_flags

// ==== verif/reg_host_model.sv ====
/*
  Host side of the byte register port: single write and read cycles.
  Assumes the design takes strobes on the rising edge of clk.
*/
`timescale 1ns/1ps
module reg_host_model (
  input  logic       clk,
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic [7:0] reg_wdata,
  output logic       reg_rd,
  input  logic [7:0] reg_rdata,
  input  logic       reg_rvalid
);
  // Idle port at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // One write; released lines show the inverse, not the old value
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  // Flag clear: ones only where flags should drop
  task automatic clear_flags(input logic [7:0] a, input logic [7:0] m);
    write_reg(a, m);
  endtask
  // One read; data and valid taken a cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
    v        = reg_rvalid;
  endtask
endmodule // reg_host_model

// ==== verif/pmic_interrupt_flags_tb_top.sv ====
/*
  Self-checking bench for the latched interrupt flags.
  Assumes the register port contract of the design and a 40 MHz clock.
*/
`timescale 1ns/1ps
module pmic_interrupt_flags_tb_top;
  import pmic_irq_pkg::*;
  logic        clk;
  logic        sys_rst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        reg_rvalid;
  logic [19:0] stim;
  logic [3:0]  enable_req;
  logic [3:0]  regulator_enable;
  logic        gpo_a_req;
  logic        gpo_b_req;
  logic        general_output_a;
  logic        general_output_b;
  logic        restart_request;
  logic        software_reset_request;
  logic        interrupt_request_n;
  int          mismatches;
  int          n_checks;
  int          n_restart;
  int          n_swrst;
  logic [51:0] rows [18];

  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  reg_host_model reg_host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  pmic_interrupt_flags #(.SC_CYCLES(8), .UNITS(4)) pmic_interrupt_flags_i (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .power_good_output(stim[0]), .sync_clock_present(stim[1]), .thermal_shutdown_live(stim[2]),
    .thermal_warning_live(stim[3]), .input_overvoltage_live(stim[4]), .analog_supply_low(stim[5]),
    .load_measure_ready(stim[6]), .unit_power_good(stim[11:8]), .unit_below_short(stim[15:12]),
    .unit_current_limit(stim[19:16]), .regulator_enable_request(enable_req),
    .general_output_a_request(gpo_a_req), .general_output_b_request(gpo_b_req),
    .regulator_enable(regulator_enable), .general_output_a(general_output_a),
    .general_output_b(general_output_b), .restart_request(restart_request),
    .software_reset_request(software_reset_request), .interrupt_request_n(interrupt_request_n));

  // Pulse counters for the reset strobes
  always @(negedge clk) begin
    if (restart_request === 1'b1) n_restart++;
    if (software_reset_request === 1'b1) n_swrst++;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Read a register and compare data and valid; the tag is built from the address
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    reg_host_model_i.read_reg(a, d, v);
    check($sformatf("reg %h", a), d, exp);
    check("rvalid", {7'h00, v}, 8'h01);
  endtask

  task automatic conclude();
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end

  // Main sequence
  initial begin
    logic [19:0] m;
    logic [7:0]  h;
    logic [7:0]  a;
    logic [7:0]  v;
    logic [7:0]  t;
    int          r0;
    sys_rst    = 1'b1;
    stim       = 20'h00F01;
    enable_req = 4'h0;
    gpo_a_req  = 1'b0;
    gpo_b_req  = 1'b0;
    // Rows: toggle mask, hold cycles, register, its value, top value
    rows = '{52'h00001_02_19_80_80, 52'h00002_06_19_10_10, 52'h00004_06_19_08_08, 52'h00008_06_19_04_04,
             52'h00010_06_19_02_02, 52'h00040_01_19_01_01, 52'h00100_02_1B_04_20, 52'h00200_02_1B_40_20,
             52'h00400_02_1C_04_40, 52'h00800_02_1C_40_40, 52'h01000_0C_1B_02_20, 52'h02000_0C_1B_20_20,
             52'h04000_0C_1C_02_40, 52'h08000_0C_1C_20_40, 52'h10000_02_1B_01_20, 52'h20000_02_1B_10_20,
             52'h40000_02_1C_01_40, 52'h80000_02_1C_10_40};
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    // Reserved and read-only writes, then reset values
    reg_host_model_i.write_reg(ADDR_CONV, 8'h88);
    reg_host_model_i.write_reg(ADDR_TOP_A, 8'h60);
    for (int i = 8'h18; i <= 8'h1D; i++) rd_chk(i[7:0], 8'h00);
    check("irq_n", {7'h00, interrupt_request_n}, 8'h01);
    // Table of single events, each latched then cleared
    foreach (rows[i]) begin
      {m, h, a, v, t} = rows[i];
      @(negedge clk);
      stim ^= m;
      repeat (h) @(negedge clk);
      stim ^= m;
      repeat (6) @(negedge clk);
      rd_chk(a, v);
      rd_chk(ADDR_TOP_A, t);
      check("irq_n", {7'h00, interrupt_request_n}, 8'h00);
      reg_host_model_i.clear_flags(a, v);
      rd_chk(a, 8'h00);
      rd_chk(ADDR_TOP_A, 8'h00);
      check("irq_n", {7'h00, interrupt_request_n}, 8'h01);
    end
    // Two flags in one unit register; summary holds until both clear
    for (int k = 0; k < 2; k++) begin
      a = k ? ADDR_LINREG : ADDR_CONV;
      @(negedge clk);
      stim ^= k ? 20'h40400 : 20'h10100;
      repeat (2) @(negedge clk);
      stim ^= k ? 20'h40400 : 20'h10100;
      repeat (6) @(negedge clk);
      reg_host_model_i.clear_flags(a, 8'h01);
      rd_chk(a, 8'h04);
      rd_chk(ADDR_TOP_A, k ? 8'h40 : 8'h20);
      reg_host_model_i.clear_flags(a, 8'h04);
      rd_chk(ADDR_TOP_A, 8'h00);
    end
    // Thermal trip, refused re-enable, then overvoltage trip
    enable_req = 4'hF;
    gpo_a_req  = 1'b1;
    gpo_b_req  = 1'b1;
    repeat (4) @(negedge clk);
    check("enables", {4'h0, regulator_enable}, 8'h0F);
    stim[2] = 1'b1;
    repeat (6) @(negedge clk);
    stim[2] = 1'b0;
    check("trip", {regulator_enable, general_output_a, general_output_b, 2'b00}, 8'h00);
    enable_req = 4'h0;
    repeat (2) @(negedge clk);
    enable_req = 4'hF;
    repeat (3) @(negedge clk);
    check("refused", {4'h0, regulator_enable}, 8'h00);
    reg_host_model_i.clear_flags(ADDR_TOP_A, 8'h08);
    enable_req = 4'h0;
    repeat (2) @(negedge clk);
    enable_req = 4'hF;
    repeat (3) @(negedge clk);
    check("reenable", {2'h0, regulator_enable, general_output_a, general_output_b}, 8'h3F);
    stim[4] = 1'b1;
    repeat (6) @(negedge clk);
    stim[4] = 1'b0;
    check("ovp", {regulator_enable, general_output_a, general_output_b, 2'b00}, 8'h00);
    reg_host_model_i.clear_flags(ADDR_TOP_A, 8'h02);
    enable_req = 4'h0;
    gpo_a_req  = 1'b0;
    gpo_b_req  = 1'b0;
    // Software reset wipes flags and leaves the reset flag
    stim[3] = 1'b1;
    repeat (6) @(negedge clk);
    stim[3] = 1'b0;
    r0 = n_restart;
    check("swrst", n_swrst[7:0], 8'h00);
    reg_host_model_i.write_reg(ADDR_RESET_CTRL, 8'h01);
    repeat (4) @(negedge clk);
    check("swrst", n_swrst[7:0], 8'h01);
    check("restart", n_restart[7:0] - r0[7:0], 8'h01);
    rd_chk(ADDR_TOP_B, 8'h01);
    rd_chk(ADDR_TOP_A, 8'h00);
    rd_chk(ADDR_RESET_CTRL, 8'h00);
    check("irq_n", {7'h00, interrupt_request_n}, 8'h00);
    reg_host_model_i.clear_flags(ADDR_TOP_B, 8'h01);
    rd_chk(ADDR_TOP_B, 8'h00);
    // Supply undervoltage as the second reset source
    stim[5] = 1'b1;
    repeat (6) @(negedge clk);
    stim[5] = 1'b0;
    rd_chk(ADDR_TOP_B, 8'h01);
    check("restart", n_restart[7:0] - r0[7:0], 8'h02);
    reg_host_model_i.clear_flags(ADDR_TOP_B, 8'h01);
    repeat (2) @(negedge clk);
    check("irq_n", {7'h00, interrupt_request_n}, 8'h01);
    // Mid-run reset wipes a pending flag and releases the request
    stim[3] = 1'b1;
    repeat (6) @(negedge clk);
    stim[3] = 1'b0;
    check("irq_n", {7'h00, interrupt_request_n}, 8'h00);
    sys_rst = 1'b1;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    check("irq_n", {7'h00, interrupt_request_n}, 8'h01);
    rd_chk(ADDR_TOP_A, 8'h00);
    conclude();
  end
endmodule // pmic_interrupt_flags_tb_top
